// ### verilog/tkot_top.sv
// touch key output timing: burst sequencer, detect output, health pulse
// assumes one 50 MHz clock; measurement counts are valid at burst end
// recalibration itself happens outside the block; recal_o only requests it
//
// Function
// R1: burst oscillator phases 3.05 us charge, 9.0 us transfer, spread 7.5 percent.
// R2: detect output high on confirmed touch, low otherwise.
// R3: output stays high while detection persists or until stuck timeout.
// R4: on stuck timeout, recalibrate and hold output low until next confirm.
// R5: release output for 15 us before every burst, in every mode.
// R6: host sees health pulses through a pull-up only while output low.
// R7: host ignores the output for 100 ms after power-up.
// R8: fast run waits 1.2 ms between bursts.
// R9: low power run sleeps 80 ms between bursts; code uses the 1.2 ms gap while a confirmation is pending.
// R10: a burst lasts 2.45 ms.
// R11: mode pin high selects fast run, low selects low power run.
// R12: four successive detections confirm; any miss clears the count.
// R13: stuck timeout counts bursts, about 60 s in low power run.
// R14: detect at 10 counts above reference, release with 2 counts hysteresis.
// R15: drive low after power-up interval; health pulse before every burst.
`timescale 1ns/1ps
`include "tkot_defines.svh"
module tkot_top #(
    parameter int unsigned POWERUP_CYCLES = `TKOT_POWERUP_US * 1000 / `TKOT_CLK_NS,
    parameter int unsigned RAPID_CYCLES   = `TKOT_RAPID_GAP_US * 1000 / `TKOT_CLK_NS,
    parameter int unsigned SLEEP_CYCLES   = `TKOT_SLEEP_GAP_US * 1000 / `TKOT_CLK_NS,
    parameter int unsigned BURST_CYCLES   = `TKOT_BURST_US * 1000 / `TKOT_CLK_NS
) (
    input  wire logic                    core_clk_i,     // core clock, 50 MHz
    input  wire logic                    arst_n_i,       // async reset, active low
    input  wire logic                    mode_sync_i,    // high fast run, low low power
    input  wire logic [`TKOT_MEAS_W-1:0] sig_count_i,    // measured signal count
    input  wire logic [`TKOT_MEAS_W-1:0] ref_count_i,    // reference count
    output logic                         detect_o,       // detect level to the pin
    output logic                         detect_oe_n_o,  // low while driving the pin
    output logic                         burst_o,        // burst in progress
    output logic                         charge_o,       // charge phase active
    output logic                         xfer_o,         // transfer phase active
    output logic                         recal_o,        // one-cycle recalibrate request
    output logic                         low_power_run_o // low power run selected
);
    localparam int unsigned HEALTH_CYCLES = `TKOT_HEALTH_NS / `TKOT_CLK_NS;
    // bursts per stuck timeout, from one full low power cycle in microseconds
    localparam int unsigned LP_CYCLE_US   = `TKOT_SLEEP_GAP_US + `TKOT_BURST_US
                                          + `TKOT_HEALTH_NS / 1000;
    localparam int unsigned MAX_ON_BURSTS = `TKOT_MAX_ON_MS * 1000 / LP_CYCLE_US;
    // release level sits two counts below the detect level
    localparam int          REL_TH        = `TKOT_DETECT_TH - `TKOT_HYST;

    // the phase timer shares the core clock, so nothing crosses a domain
    tkot_osc_if osc_bus ();

    tkot_pkg::tkot_state_t      state, next_state;
    logic [`TKOT_CNT_W-1:0]     tmr, next_tmr;
    logic [2:0]                 touch_confirm_counter, next_confirm;
    logic [10:0]                stuck_bursts, next_stuck;
    logic                       next_detect, next_oe_n, next_recal;
    logic                       next_burst, next_charge, next_xfer;
    logic                       low_power_run, next_low_power_run;
    logic signed [`TKOT_MEAS_W:0] delta;
    logic                       over_th, over_rel, burst_last, stuck_full;

    //////////////////////////////////////////////////////////////////////
    // spread-spectrum phase timer, runs only during a burst
    tkot_spread_osc u_osc (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .osc        (osc_bus.osc)
    );

    assign osc_bus.run = (state == tkot_pkg::TKOT_ST_BURST);

    // measurement compare; the hysteresis keeps a marginal touch from chattering
    // one extra bit keeps the difference of two 14-bit counts from wrapping
    assign delta    = $signed({1'b0, sig_count_i}) - $signed({1'b0, ref_count_i});
    assign over_th  = (delta >= (`TKOT_MEAS_W+1)'(`TKOT_DETECT_TH));     // R14
    assign over_rel = (delta >= (`TKOT_MEAS_W+1)'(REL_TH));              // R14
    // the last burst cycle is where the counts and the mode pin are taken
    assign burst_last = (state == tkot_pkg::TKOT_ST_BURST) && (tmr == '0);
    // stuck limit is counted in bursts, so fast run reaches it sooner
    assign stuck_full = (32'(stuck_bursts) >= MAX_ON_BURSTS - 1);        // R13

    //////////////////////////////////////////////////////////////////////
    // sequencer, confirmation and output next values
    always_comb begin
        next_state         = state;
        next_tmr           = tmr - `TKOT_CNT_W'(1);
        next_confirm       = touch_confirm_counter;
        next_stuck         = stuck_bursts;
        next_detect        = detect_o;
        next_oe_n          = 1'b0;
        next_recal         = 1'b0;
        // a state overrides these defaults when its span runs out; power-up and health also override them throughout
        unique case (state)
            tkot_pkg::TKOT_ST_POWERUP: begin
                // pin held driven low, so the host never sees it floating
                next_detect = 1'b0;                                       // R15
                if (tmr == '0) begin
                    next_state = tkot_pkg::TKOT_ST_HEALTH;
                    next_tmr   = `TKOT_CNT_W'(HEALTH_CYCLES - 1);
                    next_oe_n  = 1'b1;                                    // R15
                end
            end
            tkot_pkg::TKOT_ST_HEALTH: begin
                // a pull-up on the pin shows this window only while detect is low
                next_oe_n = 1'b1;                                         // R5
                if (tmr == '0) begin
                    next_oe_n  = 1'b0;
                    next_state = tkot_pkg::TKOT_ST_BURST;
                    next_tmr   = `TKOT_CNT_W'(BURST_CYCLES - 1);          // R10
                end
            end
            tkot_pkg::TKOT_ST_BURST: begin
                if (tmr == '0) begin
                    next_state         = tkot_pkg::TKOT_ST_GAP;
                    if (detect_o) begin
                        if (!over_rel) begin
                            next_detect = 1'b0;                           // R3
                            next_stuck  = '0;
                        end else if (stuck_full) begin
                            // stuck touch: drop the output, ask for recalibration
                            next_detect  = 1'b0;                          // R4
                            next_recal   = 1'b1;                          // R4
                            next_stuck   = '0;
                            next_confirm = 3'h0;
                        end else begin
                            next_stuck = stuck_bursts + 11'h001;          // R13
                        end
                    end else if (over_th) begin
                        // fourth successive hit confirms; the stuck count starts afresh
                        if (touch_confirm_counter == 3'(`TKOT_CONFIRM_N - 1)) begin
                            next_detect  = 1'b1;                          // R2
                            next_confirm = 3'h0;
                            next_stuck   = '0;
                        end else begin
                            next_confirm = touch_confirm_counter + 3'h1;  // R12
                        end
                    end else begin
                        // any miss before the fourth hit starts the filter over
                        next_confirm = 3'h0;                              // R12
                    end
                    // gap choice uses the just-updated confirmation state
                    if (!mode_sync_i && !(next_confirm != 3'h0 && !next_detect))
                        next_tmr = `TKOT_CNT_W'(SLEEP_CYCLES - 1);        // R9
                    else
                        next_tmr = `TKOT_CNT_W'(RAPID_CYCLES - 1);        // R8
                end
            end
            tkot_pkg::TKOT_ST_GAP: begin
                // every burst is preceded by a fresh health window
                if (tmr == '0) begin
                    next_state = tkot_pkg::TKOT_ST_HEALTH;
                    next_tmr   = `TKOT_CNT_W'(HEALTH_CYCLES - 1);         // R5
                    next_oe_n  = 1'b1;                                    // R5
                end
            end
        endcase
    end

    // register sequencer and pin state; outputs come straight from here
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state                 <= tkot_pkg::TKOT_ST_POWERUP;
            tmr                   <= `TKOT_CNT_W'(POWERUP_CYCLES - 1);    // R7
            touch_confirm_counter <= 3'h0;
            stuck_bursts          <= 11'h000;
            detect_o              <= 1'b0;
            detect_oe_n_o         <= 1'b0;
            recal_o               <= 1'b0;
        end else begin
            state                 <= next_state;
            tmr                   <= next_tmr;
            touch_confirm_counter <= next_confirm;
            stuck_bursts          <= next_stuck;
            detect_o              <= next_detect;
            detect_oe_n_o         <= next_oe_n;
            recal_o               <= next_recal;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // run mode follows the mode pin, taken only at the last burst cycle
    always_comb begin
        next_low_power_run = low_power_run;
        if (burst_last)
            next_low_power_run = !mode_sync_i;                            // R11
    end

    // register the run mode; a pin change mid-gap waits for a burst end
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            low_power_run <= 1'b0;
        end else begin
            low_power_run <= next_low_power_run;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // burst and phase indicators, gated by the next state so that a phase
    // cut short at burst end never shows up outside the burst
    always_comb begin
        next_burst  = (next_state == tkot_pkg::TKOT_ST_BURST);
        next_charge = next_burst && (osc_bus.phase == tkot_pkg::TKOT_PH_CHARGE); // R1
        next_xfer   = next_burst && (osc_bus.phase == tkot_pkg::TKOT_PH_XFER);   // R1
    end

    // register the indicators; they trail the phase timer by one cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            burst_o  <= 1'b0;
            charge_o <= 1'b0;
            xfer_o   <= 1'b0;
        end else begin
            burst_o  <= next_burst;
            charge_o <= next_charge;
            xfer_o   <= next_xfer;
        end
    end

    assign low_power_run_o = low_power_run;
endmodule : tkot_top

// ### verilog/tkot_defines.svh
// constants for the touch key output timing block: times, thresholds, seeds
// assumes a single 50 MHz core clock; times are in their printed units
`ifndef TKOT_DEFINES_SVH
`define TKOT_DEFINES_SVH

`define TKOT_CLK_NS          20      // core clock period
`define TKOT_CHARGE_NS       3050    // nominal charge phase
`define TKOT_XFER_NS         9000    // nominal transfer phase
`define TKOT_SPREAD_PERMILLE 75      // plus or minus 7.5 percent
`define TKOT_HEALTH_NS       15000   // released window before each burst
`define TKOT_POWERUP_US      100000  // output not valid after power-up
`define TKOT_RAPID_GAP_US    1200    // gap between bursts, fast run
`define TKOT_SLEEP_GAP_US    80000   // gap between bursts, low power run
`define TKOT_BURST_US        2450    // burst duration
`define TKOT_MAX_ON_MS       60000   // stuck-touch timeout in low power run
`define TKOT_DETECT_TH       10      // delta counts to declare a detection
`define TKOT_HYST            2       // release hysteresis in counts
`define TKOT_CONFIRM_N       4       // successive detections to confirm
`define TKOT_LFSR_SEED       8'ha5   // nonzero start of the spread sequence
`define TKOT_CNT_W           23      // width of the interval counter
`define TKOT_MEAS_W          14      // width of signal and reference counts

`endif

// ### verilog/tkot_pkg.sv
// types shared by the touch key output timing block
// assumes nothing beyond a SystemVerilog tool
package tkot_pkg;
    // sequencer states of the burst cycle
    typedef enum logic [1:0] {
        TKOT_ST_POWERUP = 2'b00,
        TKOT_ST_HEALTH  = 2'b01,
        TKOT_ST_BURST   = 2'b10,
        TKOT_ST_GAP     = 2'b11
    } tkot_state_t;

    // phases of the spread-spectrum burst oscillator
    typedef enum logic [1:0] {
        TKOT_PH_IDLE   = 2'b00,
        TKOT_PH_CHARGE = 2'b01,
        TKOT_PH_XFER   = 2'b10
    } tkot_phase_t;
endpackage : tkot_pkg

// ### verilog/tkot_osc_if.sv
// carrier between the burst sequencer and the spread-spectrum phase timer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface tkot_osc_if;
    logic                  run;        // burst in progress
    tkot_pkg::tkot_phase_t phase;      // current charge or transfer phase

    modport ctrl (output run, input  phase);
    modport osc  (input  run, output phase);
endinterface : tkot_osc_if

// ### verilog/tkot_spread_osc.sv
// spread-spectrum phase timer: alternates charge and transfer phases
// assumes run is held high for a whole burst and low between bursts
`timescale 1ns/1ps
`include "tkot_defines.svh"
module tkot_spread_osc (
    input  wire logic   core_clk_i,    // core clock
    input  wire logic   arst_n_i,      // async reset, active low
    tkot_osc_if.osc     osc            // run in, phase out
);
    localparam int CHG_NOM  = `TKOT_CHARGE_NS / `TKOT_CLK_NS;
    localparam int XFER_NOM = `TKOT_XFER_NS / `TKOT_CLK_NS;
    localparam int CHG_SPR  = CHG_NOM * `TKOT_SPREAD_PERMILLE / 1000;
    localparam int XFER_SPR = XFER_NOM * `TKOT_SPREAD_PERMILLE / 1000;

    // phase length = nominal - spread + lfsr share of twice the spread
    function automatic logic [8:0] tkot_len(input int nom, input int spr,
                                            input logic [7:0] rnd);
        int span;
        span = (int'(rnd) * (2 * spr)) >> 8;
        return 9'(nom - spr + span - 1);
    endfunction : tkot_len

    tkot_pkg::tkot_phase_t phase, next_phase;
    logic [8:0]            cnt, next_cnt;
    logic [7:0]            lfsr, next_lfsr;

    //////////////////////////////////////////////////////////////////////
    // next phase, length and spread sequence
    always_comb begin
        next_phase = phase;
        next_cnt   = cnt;
        next_lfsr  = lfsr;
        if (!osc.run) begin
            next_phase = tkot_pkg::TKOT_PH_IDLE;
            next_cnt   = '0;
        end else if (phase == tkot_pkg::TKOT_PH_IDLE || cnt == '0) begin
            // each new phase draws a fresh length, so no single burst frequency
            next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            if (phase == tkot_pkg::TKOT_PH_CHARGE) begin
                next_phase = tkot_pkg::TKOT_PH_XFER;
                next_cnt   = tkot_len(XFER_NOM, XFER_SPR, lfsr);      // R1
            end else begin
                next_phase = tkot_pkg::TKOT_PH_CHARGE;
                next_cnt   = tkot_len(CHG_NOM, CHG_SPR, lfsr);        // R1
            end
        end else begin
            next_cnt = cnt - 9'h001;
        end
    end

    // register the phase timer
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase <= tkot_pkg::TKOT_PH_IDLE;
            cnt   <= 9'h000;
            lfsr  <= `TKOT_LFSR_SEED;
        end else begin
            phase <= next_phase;
            cnt   <= next_cnt;
            lfsr  <= next_lfsr;
        end
    end

    assign osc.phase = phase;
endmodule : tkot_spread_osc

// ### tb/tkot_properties.sv
// concurrent checks on the detect pin, burst and health timing of tkot_top
// assumes it is bound to tkot_top and sees only the ports of that module
`timescale 1ns/1ps
`include "tkot_defines.svh"
module tkot_properties #(
    parameter int unsigned POWERUP_CYCLES = 20,
    parameter int unsigned RAPID_CYCLES   = 10,
    parameter int unsigned SLEEP_CYCLES   = 30,
    parameter int unsigned BURST_CYCLES   = 40
) (
    input wire logic core_clk_i,      // core clock
    input wire logic arst_n_i,        // async reset, active low
    input wire logic detect_o,        // detect level
    input wire logic detect_oe_n_o,   // low while driving
    input wire logic burst_o,         // burst in progress
    input wire logic charge_o,        // charge phase
    input wire logic xfer_o,          // transfer phase
    input wire logic recal_o,         // recalibrate pulse
    input wire logic low_power_run_o  // low power run
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [31:0] hi_cnt;
    logic [31:0] b_cnt;
    logic [31:0] g_cnt;
    logic [31:0] up_cnt;
    logic        seen;
    logic [15:0] c_run;
    logic [15:0] x_run;
    // phase length bounds: nominal times widened by the 7.5 percent spread
    localparam int CHG_NOM = `TKOT_CHARGE_NS / `TKOT_CLK_NS;
    localparam int XFR_NOM = `TKOT_XFER_NS / `TKOT_CLK_NS;
    localparam int CHG_SPR = CHG_NOM * `TKOT_SPREAD_PERMILLE / 1000;
    localparam int XFR_SPR = XFR_NOM * `TKOT_SPREAD_PERMILLE / 1000;
    // run lengths; counters avoid long repetitions the tools would unroll
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_cnt <= 32'h0;
            b_cnt  <= 32'h0;
            g_cnt  <= 32'h0;
            up_cnt <= 32'h0;
            seen   <= 1'b0;
            c_run  <= 16'h0;
            x_run  <= 16'h0;
        end else begin
            hi_cnt <= detect_oe_n_o ? hi_cnt + 32'h1 : 32'h0;
            b_cnt  <= burst_o ? b_cnt + 32'h1 : 32'h0;
            g_cnt  <= (burst_o || detect_oe_n_o) ? 32'h0 : g_cnt + 32'h1;
            up_cnt <= (up_cnt < POWERUP_CYCLES) ? up_cnt + 32'h1 : up_cnt;
            seen   <= seen | burst_o;
            c_run  <= charge_o ? c_run + 16'h1 : 16'h0;
            x_run  <= xfer_o ? x_run + 16'h1 : 16'h0;
        end
    end
    sequence burst_end;
        $fell(burst_o);
    endsequence
    sequence health_end;
        $fell(detect_oe_n_o) ##0 burst_o;
    endsequence
    health_width_a: assert property ($fell(detect_oe_n_o) |-> hi_cnt == 750)
        else $error("health window width wrong");
    health_then_burst_a: assert property ($fell(detect_oe_n_o) |-> health_end)
        else $error("burst did not follow health window");
    driven_in_burst_a: assert property (burst_o |-> !detect_oe_n_o)
        else $error("pin released during burst");
    burst_length_a: assert property (burst_end |-> b_cnt == BURST_CYCLES)
        else $error("burst length wrong");
    gap_length_a: assert property ($rose(detect_oe_n_o) && seen |->
        (g_cnt == RAPID_CYCLES || (low_power_run_o && g_cnt == SLEEP_CYCLES)))
        else $error("gap between bursts wrong");
    detect_at_end_a: assert property ($changed(detect_o) |-> burst_end)
        else $error("detect changed outside burst end");
    recal_pulse_a: assert property (recal_o |-> burst_end ##0 !detect_o ##1 !recal_o)
        else $error("recalibrate pulse malformed");
    powerup_quiet_a: assert property (up_cnt < POWERUP_CYCLES - 1 |->
        !detect_oe_n_o && !detect_o && !burst_o)
        else $error("activity during power-up interval");
    phase_in_burst_a: assert property ((charge_o || xfer_o) |->
        burst_o && !(charge_o && xfer_o))
        else $error("oscillator phase outside burst");
    charge_len_a: assert property ($fell(charge_o) && burst_o |->
        c_run >= CHG_NOM - CHG_SPR && c_run <= CHG_NOM + CHG_SPR)
        else $error("charge phase length outside spread");
    xfer_len_a: assert property ($fell(xfer_o) && burst_o |->
        x_run >= XFR_NOM - XFR_SPR && x_run <= XFR_NOM + XFR_SPR)
        else $error("transfer phase length outside spread");
endmodule : tkot_properties

bind tkot_top tkot_properties #(
    .POWERUP_CYCLES(POWERUP_CYCLES),
    .RAPID_CYCLES  (RAPID_CYCLES),
    .SLEEP_CYCLES  (SLEEP_CYCLES),
    .BURST_CYCLES  (BURST_CYCLES)
) u_tkot_properties (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .detect_o(detect_o),
    .detect_oe_n_o(detect_oe_n_o), .burst_o(burst_o), .charge_o(charge_o),
    .xfer_o(xfer_o), .recal_o(recal_o), .low_power_run_o(low_power_run_o)
);

// ### tb/tkot_host_model.sv
// host logic on the detect pin: pull-up resolution and health pulse counter
// assumes the pin pulls high when released; counts short high runs only
`timescale 1ns/1ps
module tkot_host_model #(
    parameter int unsigned POWERUP_CYCLES = 20
) (
    input  wire logic        core_clk_i,    // core clock
    input  wire logic        arst_n_i,      // async reset, active low
    input  wire logic        detect_i,      // level driven by the device
    input  wire logic        detect_oe_n_i, // low while device drives
    output logic             pin_level_o,   // resolved pin level
    output logic [15:0]      pulse_count_o  // health pulses seen
);
    logic [31:0] hi_run;
    logic [31:0] up_cnt;
    // pull-up wins whenever the device lets go of the pin
    assign pin_level_o = detect_oe_n_i ? 1'b1 : detect_i;
    // a detect high lasts a whole burst cycle, so only short runs are pulses
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hi_run        <= 32'h0;
            up_cnt        <= 32'h0;
            pulse_count_o <= 16'h0;
        end else begin
            up_cnt <= (up_cnt < POWERUP_CYCLES) ? up_cnt + 32'h1 : up_cnt;
            hi_run <= pin_level_o ? hi_run + 32'h1 : 32'h0;
            if (up_cnt >= POWERUP_CYCLES && !pin_level_o && hi_run != 0 && hi_run <= 760)
                pulse_count_o <= pulse_count_o + 16'h1;
        end
    end
endmodule : tkot_host_model

// ### tb/touch_key_output_timing_bench.sv
// testbench for tkot_top: confirm filter, release, run modes, health pulses
// assumes shortened counts and the host model on the detect pin
`timescale 1ns/1ps
module touch_key_output_timing_bench;
    localparam int unsigned P_UP = 20;
    localparam int unsigned P_RAPID = 10;
    localparam int unsigned P_SLEEP = 30;
    localparam int unsigned P_BURST = 800;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        mode = 1'b1;
    logic [13:0] sig_cnt = 14'h0064;
    logic [13:0] ref_cnt = 14'h0064;
    logic        det, oe_n, burst, chg, xfr, recal, lpr, pin;
    logic [15:0] pulses;
    int          num_errors = 0;
    int          check_count = 0;
    int          exp_pulses = 0;
    // 50 MHz core clock
    always #10 clk = ~clk;
    tkot_top #(.POWERUP_CYCLES(P_UP), .RAPID_CYCLES(P_RAPID),
        .SLEEP_CYCLES(P_SLEEP), .BURST_CYCLES(P_BURST)) u_tkot_top (
        .core_clk_i(clk), .arst_n_i(arst_n), .mode_sync_i(mode), .sig_count_i(sig_cnt),
        .ref_count_i(ref_cnt), .detect_o(det), .detect_oe_n_o(oe_n), .burst_o(burst),
        .charge_o(chg), .xfer_o(xfr), .recal_o(recal), .low_power_run_o(lpr));
    tkot_host_model #(.POWERUP_CYCLES(P_UP)) u_tkot_host_model (
        .core_clk_i(clk), .arst_n_i(arst_n), .detect_i(det), .detect_oe_n_i(oe_n),
        .pin_level_o(pin), .pulse_count_o(pulses));
    task automatic check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    // counts are only sampled at burst end, so they are set before the burst
    task automatic do_burst(input logic [13:0] delta);
        int n;
        n = 0;
        sig_cnt = ref_cnt + delta;
        if (det === 1'b0) exp_pulses++;
        while (burst !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
        while (burst === 1'b1 && n < 5000) begin @(negedge clk); n++; end
    endtask : do_burst
    task automatic test_powerup();
        int n;
        n = 0;
        while (oe_n !== 1'b1 && n < 100) begin
            check("detect in power-up", det, 1'b0);
            @(negedge clk);
            n++;
        end
        check("power-up span", n > P_UP - 2 && n < P_UP + 2, 1'b1);
        n = 0;
        while (oe_n === 1'b1 && n < 2000) begin @(negedge clk); n++; end
        check("health width", n, 750);
        $display("test_powerup done");
    endtask : test_powerup
    task automatic test_confirm();
        for (int i = 0; i < 3; i++) do_burst(14'd10);
        do_burst(14'd9);
        check("miss clears count", det, 1'b0);
        for (int i = 0; i < 3; i++) do_burst(14'd10);
        check("three hits", det, 1'b0);
        do_burst(14'd10);
        check("fourth hit", det, 1'b1);
        $display("test_confirm done");
    endtask : test_confirm
    task automatic test_release();
        do_burst(14'd8);
        check("held in hysteresis", det, 1'b1);
        do_burst(14'd7);
        check("released", det, 1'b0);
        $display("test_release done");
    endtask : test_release
    task automatic test_gap(input logic m, input logic exp_slow);
        int n;
        n = 0;
        mode = m;
        do_burst(14'd0);
        check("low power flag", lpr, !m);
        while (oe_n !== 1'b1 && n < 200) begin @(negedge clk); n++; end
        check("gap class", n > (P_RAPID + P_SLEEP) / 2, exp_slow);
        $display("test_gap done");
    endtask : test_gap
    task automatic test_health();
        do_burst(14'd0);
        check("visible pulses", pulses, exp_pulses);
        $display("test_health done");
    endtask : test_health
    // watchdog well beyond the expected run
    initial begin
        #2000000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        test_powerup();
        test_confirm();
        test_release();
        test_gap(1'b0, 1'b1);
        test_gap(1'b1, 1'b0);
        test_health();
        stop_test();
    end
endmodule : touch_key_output_timing_bench
